// File: inc/dtc_defs.svh
/*
 * Register offsets, field positions, reset values and prescaler exponents
 * for the dual timer/counter block.
 * Assumes byte addressing on a 32-bit AHB-Lite bus, one word per register.
 */
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define DTC_OFF_MODE_A   8'h00
`define DTC_OFF_MODE_B   8'h04
`define DTC_OFF_ALTFUNC  8'h08
`define DTC_OFF_MATCH_A  8'h0C
`define DTC_OFF_MATCH_B  8'h10
`define DTC_OFF_COUNT    8'h14
`define DTC_OFF_CAPTURE  8'h18
`define DTC_OFF_STATUS   8'h1C
`define DTC_OFF_MASK     8'h20
`define DTC_OFF_EDGE     8'h24

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DTC_A_CAP_BIT    3
`define DTC_B_CAP_BIT    2
`define DTC_B_PWM_BIT    3
`define DTC_B_CHAIN_BIT  4
`define DTC_PIN_FUNC_BIT 4
`define DTC_ST_MATCH_A   0
`define DTC_ST_MATCH_B   1
`define DTC_ST_EDGE_A    2
`define DTC_ST_EDGE_B    3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DTC_RST_BYTE     8'h00
`define DTC_RST_NIB      4'h0

// ------------------------------------------------------------
// prescaler: exponent of two for each tap, tap 0 is divide by one
// ------------------------------------------------------------
`define DTC_PRE_TAPS     8
`define DTC_PRE_BITS     11
`define DTC_PRE_EXP(i)   ((i) == 0 ? 0 : (i) == 1 ? 1 : (i) == 2 ? 2 : \
	(i) == 3 ? 3 : (i) == 4 ? 5 : (i) == 5 ? 7 : (i) == 6 ? 9 : 11)
`define DTC_EXT_CLK_SEL  3'h7
`define DTC_CHAIN_CLK    2'h3

`endif

// File: inc/dtc_pkg.sv
/*
 * Types shared by the dual timer/counter block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dtc_pkg;

	typedef logic [7:0] dtc_byte_t;

	// edge selection of a capture pin
	typedef enum logic [1:0]
	{
		DTC_EDGE_FALL = 2'h0,
		DTC_EDGE_RISE = 2'h1,
		DTC_EDGE_BOTH = 2'h2
	} dtc_edge_t;

endpackage

// File: rtl/dtc_prescaler.sv
/*
 * Free running prescaler for the timer/counter pair: one pulse per
 * 1, 2, 4, 8, 32, 128, 512 or 2048 clocks.
 * Assumes the system clock is the oscillator rate seen by the timers.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defs.svh"

module dtc_prescaler
(
	input  wire logic                      clock,
	input  wire logic                      rst,
	output logic [`DTC_PRE_TAPS-1:0]       tick
);

	logic [`DTC_PRE_BITS-1:0] div_reg;

	always_ff @(posedge clock)
	begin
		if (rst)
			div_reg <= '0;
		else
			div_reg <= div_reg + 11'h001;
	end

	// ------------------------------------------------------------
	// taps
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `DTC_PRE_TAPS; i++)
		begin : g_tap
			if (`DTC_PRE_EXP(i) == 0)
			begin : g_one
				assign tick[i] = 1'b1;
			end
			else
			begin : g_div
				assign tick[i] = &div_reg[`DTC_PRE_EXP(i)-1:0];
			end
		end
	endgenerate

endmodule

`default_nettype wire

// File: rtl/dtc_top.sv
/*
 * Dual 8-bit timer/counter, chainable to 16 bits, with capture, compare
 * output toggle, sticky interrupt status and an AHB-Lite register slave.
 * Assumes synchronous inputs, a single 20 MHz clock and single word
 * transfers; the pwm waveform itself lives outside this block.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defs.svh"

module dtc_top
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        event_count_input,
	input  wire logic        capture_pin_a,
	input  wire logic        capture_pin_b,
	output logic             compare_out,
	output logic             irq
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	dtc_pkg::dtc_byte_t timer_a_mode_reg;
	dtc_pkg::dtc_byte_t timer_b_mode_reg;
	dtc_pkg::dtc_byte_t port_b_altfunc_reg;
	dtc_pkg::dtc_byte_t timer_a_match_reg;
	dtc_pkg::dtc_byte_t timer_b_match_reg;
	dtc_pkg::dtc_byte_t count_a_reg;
	dtc_pkg::dtc_byte_t count_b_reg;
	dtc_pkg::dtc_byte_t capture_a_reg;
	dtc_pkg::dtc_byte_t capture_b_reg;
	logic [3:0]         status_reg;
	logic [3:0]         mask_reg;
	logic [3:0]         edge_reg;
	logic               event_prev_reg;
	logic               pin_a_prev_reg;
	logic               pin_b_prev_reg;
	logic               wr_pend_reg;
	logic [7:0]         wr_addr_reg;
	logic               compare_out_reg;
	logic               irq_reg;
	logic [31:0]        hrdata_reg;
	logic               hreadyout_reg;
	assign hrdata    = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp     = 1'b0;
	assign compare_out = compare_out_reg;
	assign irq       = irq_reg;
	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	wire [2:0] timer_a_clock_sel   = timer_a_mode_reg[2:0];
	wire       timer_a_capture_sel = timer_a_mode_reg[`DTC_A_CAP_BIT];
	wire [1:0] timer_b_clock_sel   = timer_b_mode_reg[1:0];
	wire       timer_b_capture_sel = timer_b_mode_reg[`DTC_B_CAP_BIT];
	wire       pulse_width_mode_on = timer_b_mode_reg[`DTC_B_PWM_BIT];
	wire       chain_sixteen_sel   = timer_b_mode_reg[`DTC_B_CHAIN_BIT];
	wire       compare_pin_func_sel =
		port_b_altfunc_reg[`DTC_PIN_FUNC_BIT];

	// chaining needs timer b clock 11; otherwise the pair stays split
	wire chain_on  = chain_sixteen_sel &
		(timer_b_clock_sel == `DTC_CHAIN_CLK);
	wire pwm_on    = pulse_width_mode_on & ~chain_on;
	wire cap_a_on  = timer_a_capture_sel;
	// timer b capture bit is ignored once chained or in pwm
	wire cap_b_on  = timer_b_capture_sel & ~chain_on & ~pwm_on;
	wire cmp_on    = compare_pin_func_sel & ~pwm_on;
	// ------------------------------------------------------------
	// clock sources
	// ------------------------------------------------------------
	logic [`DTC_PRE_TAPS-1:0] pre_tick;
	dtc_prescaler u_prescaler
	(
		.clock (clock),
		.rst   (rst),
		.tick  (pre_tick)
	);
	wire       event_rise = event_count_input & ~event_prev_reg;
	wire [2:0] tap_a      = 3'(timer_a_clock_sel + 3'h1);
	wire       tick_a     = (timer_a_clock_sel == `DTC_EXT_CLK_SEL) ?
		event_rise : pre_tick[tap_a];
	// 00, 01, 10 are the fast sources; 11 follows timer a's clock
	wire       tick_b     = (timer_b_clock_sel == 2'h0) ? pre_tick[0] :
		(timer_b_clock_sel == 2'h1) ? pre_tick[1] :
		(timer_b_clock_sel == 2'h2) ? pre_tick[3] : tick_a;
	// ------------------------------------------------------------
	// capture pin edges
	// ------------------------------------------------------------
	function automatic logic edge_hit(input logic prev, input logic cur,
		input logic [1:0] sel);
		logic rise;
		logic fall;
		rise = cur & ~prev;
		fall = ~cur & prev;
		unique case (sel)
			dtc_pkg::DTC_EDGE_FALL: edge_hit = fall;
			dtc_pkg::DTC_EDGE_RISE: edge_hit = rise;
			default:                edge_hit = rise | fall;
		endcase
	endfunction
	wire edge_a   = edge_hit(pin_a_prev_reg, capture_pin_a, edge_reg[1:0]);
	wire edge_b   = edge_hit(pin_b_prev_reg, capture_pin_b, edge_reg[3:2]);
	wire cap_a_ev = cap_a_on & edge_a;
	wire cap_b_ev = cap_b_on & edge_b;
	// ------------------------------------------------------------
	// count, match and capture
	// ------------------------------------------------------------
	wire eq_a     = count_a_reg == timer_a_match_reg;
	wire eq_b     = count_b_reg == timer_b_match_reg;
	wire eq_16    = eq_a & eq_b;
	wire carry_a  = count_a_reg == 8'hFF;
	wire wrap_a8  = ~chain_on & tick_a & eq_a & ~cap_a_ev;
	wire wrap_16  = chain_on & tick_a & eq_16 & ~cap_a_ev;
	wire wrap_b8  = ~chain_on & tick_b & eq_b & ~cap_b_ev;
	wire step_a   = tick_a & ~cap_a_ev & ~(wrap_a8 | wrap_16);
	wire step_b16 = chain_on & step_a & carry_a;
	wire step_b8  = ~chain_on & tick_b & ~cap_b_ev & ~wrap_b8;

	// capture wins over a tick arriving in the same cycle
	wire [7:0] count_a_next = (cap_a_ev | wrap_a8 | wrap_16) ? 8'h00 :
		step_a ? 8'(count_a_reg + 8'h01) : count_a_reg;
	wire clr_b = chain_on ? (cap_a_ev | wrap_16) : (cap_b_ev | wrap_b8);
	wire [7:0] count_b_next = clr_b ? 8'h00 :
		(step_b16 | step_b8) ? 8'(count_b_reg + 8'h01) : count_b_reg;
	wire set_match_a = wrap_a8 | wrap_16;
	wire set_match_b = wrap_b8;
	wire cmp_toggle  = cmp_on & (chain_on ? wrap_16 : wrap_b8);
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			count_a_reg <= `DTC_RST_BYTE;
			count_b_reg <= `DTC_RST_BYTE;
			capture_a_reg <= `DTC_RST_BYTE;
			capture_b_reg <= `DTC_RST_BYTE;
			compare_out_reg <= 1'b0;
		end
		else
		begin
			count_a_reg <= count_a_next;
			count_b_reg <= count_b_next;
			if (cap_a_ev)
				capture_a_reg <= count_a_reg;
			if ((cap_a_ev & chain_on) | cap_b_ev)
				capture_b_reg <= count_b_reg;
			compare_out_reg <= compare_out_reg ^ cmp_toggle;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			event_prev_reg <= 1'b0;
			pin_a_prev_reg <= 1'b0;
			pin_b_prev_reg <= 1'b0;
		end
		else
		begin
			event_prev_reg <= event_count_input;
			pin_a_prev_reg <= capture_pin_a;
			pin_b_prev_reg <= capture_pin_b;
		end
	end
	// ------------------------------------------------------------
	// ahb-lite slave
	// ------------------------------------------------------------
	wire        bus_take = hsel & htrans[1] & hready;
	wire [7:0]  rd_addr  = haddr[7:0];
	wire        wr_now   = wr_pend_reg;
	wire [7:0]  wdata    = hwdata[7:0];
	wire        wr_mode_a  = wr_now & (wr_addr_reg == `DTC_OFF_MODE_A);
	wire        wr_mode_b  = wr_now & (wr_addr_reg == `DTC_OFF_MODE_B);
	wire        wr_alt     = wr_now & (wr_addr_reg == `DTC_OFF_ALTFUNC);
	wire        wr_match_a = wr_now & (wr_addr_reg == `DTC_OFF_MATCH_A);
	wire        wr_match_b = wr_now & (wr_addr_reg == `DTC_OFF_MATCH_B);
	wire        wr_status  = wr_now & (wr_addr_reg == `DTC_OFF_STATUS);
	wire        wr_mask    = wr_now & (wr_addr_reg == `DTC_OFF_MASK);
	wire        wr_edge    = wr_now & (wr_addr_reg == `DTC_OFF_EDGE);

	wire [3:0] status_set = {cap_b_on & edge_b, cap_a_on & edge_a,
		set_match_b, set_match_a};
	wire [3:0] status_clr = wr_status ? hwdata[3:0] : 4'h0;
	// a new event beats a write-one-to-clear in the same cycle
	wire [3:0] status_next = (status_reg & ~status_clr) | status_set;

	// unmapped offsets read as zero
	wire [31:0] rd_data =
		(rd_addr == `DTC_OFF_MODE_A)  ? {24'h0, timer_a_mode_reg} :
		(rd_addr == `DTC_OFF_MODE_B)  ? {24'h0, timer_b_mode_reg} :
		(rd_addr == `DTC_OFF_ALTFUNC) ? {24'h0, port_b_altfunc_reg} :
		(rd_addr == `DTC_OFF_MATCH_A) ? {24'h0, timer_a_match_reg} :
		(rd_addr == `DTC_OFF_MATCH_B) ? {24'h0, timer_b_match_reg} :
		(rd_addr == `DTC_OFF_COUNT)   ? {16'h0, count_b_reg, count_a_reg} :
		(rd_addr == `DTC_OFF_CAPTURE) ?
			{16'h0, capture_b_reg, capture_a_reg} :
		(rd_addr == `DTC_OFF_STATUS)  ? {28'h0, status_reg} :
		(rd_addr == `DTC_OFF_MASK)    ? {28'h0, mask_reg} :
		(rd_addr == `DTC_OFF_EDGE)    ? {28'h0, edge_reg} : 32'h0;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg <= 32'h0;
			hreadyout_reg <= 1'b1;
		end
		else
		begin
			wr_pend_reg <= bus_take & hwrite;
			wr_addr_reg <= rd_addr;
			hreadyout_reg <= 1'b1;
			if (bus_take & ~hwrite)
				hrdata_reg <= rd_data;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			timer_a_mode_reg <= `DTC_RST_BYTE;
			timer_b_mode_reg <= `DTC_RST_BYTE;
			port_b_altfunc_reg <= `DTC_RST_BYTE;
			timer_a_match_reg <= `DTC_RST_BYTE;
			timer_b_match_reg <= `DTC_RST_BYTE;
			mask_reg <= `DTC_RST_NIB;
			edge_reg <= `DTC_RST_NIB;
		end
		else
		begin
			if (wr_mode_a)
				timer_a_mode_reg <= wdata;
			if (wr_mode_b)
				timer_b_mode_reg <= wdata;
			if (wr_alt)
				port_b_altfunc_reg <= wdata;
			if (wr_match_a)
				timer_a_match_reg <= wdata;
			if (wr_match_b)
				timer_b_match_reg <= wdata;
			if (wr_mask)
				mask_reg <= hwdata[3:0];
			if (wr_edge)
				edge_reg <= hwdata[3:0];
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			status_reg <= `DTC_RST_NIB;
			irq_reg <= 1'b0;
		end
		else
		begin
			status_reg <= status_next;
			irq_reg <= |(status_next & mask_reg);
		end
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_cap_a_8;
		cap_a_ev && !chain_on;
	endsequence
	sequence s_cleared_copy;
		count_a_reg == 8'h00 && capture_a_reg == $past(count_a_reg);
	endsequence
	a_match_a_wrap: assert property (
		(!chain_on && tick_a && eq_a && !cap_a_ev)
		|=> (count_a_reg == 8'h00 && status_reg[`DTC_ST_MATCH_A]))
		else $error("timer a did not wrap and flag on match");
	a_chain_no_b: assert property (
		(chain_on && wrap_16 && !status_reg[`DTC_ST_MATCH_B]
		&& !wr_status) |=> !status_reg[`DTC_ST_MATCH_B])
		else $error("16-bit match raised timer b interrupt");
	a_capture_copy: assert property (
		s_cap_a_8 |=> s_cleared_copy)
		else $error("capture did not copy count and clear it");
	a_event_count: assert property (
		(timer_a_clock_sel == 3'h7 && !chain_on && !cap_a_ev
		&& event_rise && !eq_a)
		|=> count_a_reg == 8'($past(count_a_reg) + 8'h01))
		else $error("event edge did not advance timer a");
	a_slow_tap_gap: assert property (
		pre_tick[7] |=> !pre_tick[7] [*8])
		else $error("divide by 2048 tap pulsed too soon");
	a_b_fast_clk: assert property (
		(timer_b_clock_sel == 2'h0 && !chain_on && !cap_b_ev && !eq_b)
		|=> count_b_reg == 8'($past(count_b_reg) + 8'h01))
		else $error("timer b divide by one did not count");
	a_chain_hold: assert property (
		(chain_on && !carry_a && !cap_a_ev && !wrap_16)
		|=> $stable(count_b_reg))
		else $error("chained upper byte moved without carry");
	a_pin_func: assert property (
		(wr_alt && wdata[4]) |=> ##1 compare_pin_func_sel)
		else $error("port b bit 4 did not select pin function");
	a_irq_level: assert property (
		(|(status_reg & mask_reg)) && !wr_status && !wr_mask |=> irq_reg)
		else $error("masked-in status did not raise irq");
endmodule

`default_nettype wire

// File: verif/dtc_pin_model.sv
/*
 * Far-side pin model: the external event input and the two capture pins.
 * Assumes the bench calls its tasks one at a time; pins idle low and
 * change only just after a rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

module dtc_pin_model
(
	input  wire logic clock,
	output logic      event_pin,
	output logic      cap_a_pin,
	output logic      cap_b_pin
);
	// ------------------------------------------------------------
	// pin stimulus
	// ------------------------------------------------------------
	initial
	begin
		event_pin = 1'b0;
		cap_a_pin = 1'b0;
		cap_b_pin = 1'b0;
	end

	// pulses are two clocks wide so the one-cycle input stage sees each
	task automatic pulse_events(input int n);
		repeat (n)
		begin
			@(posedge clock);
			event_pin <= 1'b1;
			repeat (2) @(posedge clock);
			event_pin <= 1'b0;
			repeat (2) @(posedge clock);
		end
	endtask

	// one rising edge on the chosen capture pin, then back low
	task automatic capture_edge(input logic pin_b);
		@(posedge clock);
		if (pin_b)
			cap_b_pin <= 1'b1;
		else
			cap_a_pin <= 1'b1;
		repeat (3) @(posedge clock);
		cap_a_pin <= 1'b0;
		cap_b_pin <= 1'b0;
		repeat (3) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
/*
 * Self-checking bench for the dual timer/counter: AHB-Lite register
 * tasks, pin model, scenario sequence and verdict.
 * Assumes dtc_top with hreadyout fed back as hready, and dtc_pin_model.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dtc_defs.svh"

module testbench;
	logic        clock;
	logic        rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        ev_pin;
	logic        cap_a;
	logic        cap_b;
	logic        compare_out;
	logic        irq;
	logic [31:0] c1;
	logic [31:0] rd;
	int          error_cnt;
	int          n_checks;
	logic [7:0]  exp_a [3] = '{8'h20, 8'h10, 8'h08};
	logic [7:0]  exp_b [3] = '{8'h40, 8'h20, 8'h08};

	dtc_top dtc_top_i
	(
		.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.event_count_input(ev_pin), .capture_pin_a(cap_a),
		.capture_pin_b(cap_b), .compare_out(compare_out), .irq(irq)
	);

	dtc_pin_model dtc_pin_model_i
	(
		.clock(clock), .event_pin(ev_pin), .cap_a_pin(cap_a),
		.cap_b_pin(cap_b)
	);

	always #25 clock = ~clock;

	// ------------------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------------------
	task automatic bus_op(input logic wr, input logic [7:0] off,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h000000, off};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		q = hrdata;
		hsel <= 1'b0;
	endtask

	task automatic bus_write(input logic [7:0] off, input logic [31:0] d);
		logic [31:0] q;
		bus_op(1'b1, off, d, q);
	endtask

	task automatic check(input string name, input logic [31:0] exp, got);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic read_check(input string name, input logic [7:0] off,
		input logic [31:0] exp);
		logic [31:0] q;
		bus_op(1'b0, off, 32'h00000000, q);
		check(name, exp, q);
	endtask

	// count rates are phase dependent, so allow two ticks either way
	task automatic check_near(input string name, input logic [7:0] exp, got);
		logic [7:0] d;
		d = got - exp + 8'h02;
		n_checks++;
		if ((^got === 1'bx) || d > 8'h04)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// irq moves with status but lags a mask write by a cycle; look once the updates have landed
	task automatic check_irq(input logic exp);
		repeat (2) @(posedge clock);
		#1;
		check("irq", {31'h0, exp}, {31'h0, irq});
	endtask

	// fresh reset, then modes and matches; zero matches after reset set the match flags, so clear them
	task automatic cfg(input logic [7:0] ma, mb, alt, ta, tb);
		rst <= 1'b1;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		bus_write(`DTC_OFF_MODE_A, {24'h000000, ma});
		bus_write(`DTC_OFF_MODE_B, {24'h000000, mb});
		bus_write(`DTC_OFF_ALTFUNC, {24'h000000, alt});
		bus_write(`DTC_OFF_MATCH_A, {24'h000000, ta});
		bus_write(`DTC_OFF_MATCH_B, {24'h000000, tb});
		bus_write(`DTC_OFF_STATUS, 32'h0000000F);
	endtask

	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	initial
	begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		error_cnt = 0;
		n_checks = 0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 10; i++)
			if (i != 7)
				read_check("reset value", 8'(4 * i), 32'h0);
		check_irq(1'b0);
		bus_write(8'h3C, 32'hFFFFFFFF);
		read_check("unmapped", 8'h3C, 32'h00000000);
		check("okay response", 32'h0, {31'h0, hresp});

		cfg(8'h07, 8'h03, 8'h00, 8'hFF, 8'hFF);
		dtc_pin_model_i.pulse_events(5);
		read_check("event count", `DTC_OFF_COUNT, 32'h0505);

		cfg(8'h07, 8'h03, 8'h00, 8'h03, 8'hFF);
		bus_write(`DTC_OFF_MASK, 32'h1);
		dtc_pin_model_i.pulse_events(3);
		read_check("count at match", `DTC_OFF_COUNT, 32'h0303);
		read_check("no flag yet", `DTC_OFF_STATUS, 32'h0);
		check_irq(1'b0);
		dtc_pin_model_i.pulse_events(1);
		read_check("count wrapped", `DTC_OFF_COUNT, 32'h0400);
		read_check("match flag", `DTC_OFF_STATUS, 32'h1);
		check_irq(1'b1);
		bus_write(`DTC_OFF_MASK, 32'h0);
		check_irq(1'b0);
		bus_write(`DTC_OFF_MASK, 32'h1);
		check_irq(1'b1);
		bus_write(`DTC_OFF_STATUS, 32'h1);
		read_check("flag cleared", `DTC_OFF_STATUS, 32'h0);
		check_irq(1'b0);

		cfg(8'h07, 8'h13, 8'h00, 8'h04, 8'h01);
		// the wrap comes on the tick after the count reaches the match
		dtc_pin_model_i.pulse_events(260);
		read_check("chained count", `DTC_OFF_COUNT, 32'h0104);
		read_check("chained no flag", `DTC_OFF_STATUS, 32'h0);
		dtc_pin_model_i.pulse_events(1);
		read_check("chained wrap", `DTC_OFF_COUNT, 32'h0);
		read_check("chained flag", `DTC_OFF_STATUS, 32'h1);

		cfg(8'h07, 8'h03, 8'h10, 8'hFF, 8'h01);
		read_check("pin function", `DTC_OFF_ALTFUNC, 32'h10);
		dtc_pin_model_i.pulse_events(2);
		check("compare high", 32'h1, {31'h0, compare_out});
		read_check("b match flag", `DTC_OFF_STATUS, 32'h2);
		dtc_pin_model_i.pulse_events(2);
		check("compare low", 32'h0, {31'h0, compare_out});
		bus_write(`DTC_OFF_MODE_B, 32'h0B);
		dtc_pin_model_i.pulse_events(2);
		check("pwm owns pin", 32'h0, {31'h0, compare_out});

		// third pass: pin b on both edges, the fall recaptures the cleared count
		for (int b = 0; b < 3; b++)
		begin
			cfg(b ? 8'h07 : 8'h0F, b ? 8'h07 : 8'h03, b ? 8'h00 : 8'h10,
				8'hFF, 8'hFF);
			bus_write(`DTC_OFF_EDGE, (b == 2) ? 32'h9 : 32'h5);
			dtc_pin_model_i.pulse_events(6);
			read_check("capture counting", `DTC_OFF_COUNT, 32'h0606);
			dtc_pin_model_i.capture_edge(b != 0);
			read_check("captured", `DTC_OFF_CAPTURE,
				(b == 0) ? 32'h0006 : (b == 1) ? 32'h0600 : 32'h0);
			read_check("cleared", `DTC_OFF_COUNT,
				b ? 32'h0006 : 32'h0600);
			read_check("edge flag", `DTC_OFF_STATUS, b ? 32'h8 : 32'h4);
		end

		for (int i = 0; i < 3; i++)
		begin
			cfg(8'(i), 8'(i), 8'h00, 8'hFF, 8'hFF);
			bus_op(1'b0, `DTC_OFF_COUNT, 32'h0, c1);
			repeat (61) @(posedge clock);
			bus_op(1'b0, `DTC_OFF_COUNT, 32'h0, rd);
			check_near("rate a", exp_a[i], rd[7:0] - c1[7:0]);
			check_near("rate b", exp_b[i], rd[15:8] - c1[15:8]);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
